// ---- rbs_cfg.svh ----
// Constants for the reset and boot strap configuration block.
// Assumes a single 100 MHz system clock and an asynchronous active-low reset pin.
// Function
// - Reset aborts activity, restarts at boot vector
// - Reset accepted asynchronously, synchronized internally
// - First fetch about 6.5 clocks after release
// - Power-on I/O defaults: normal, pulldown, pullup
// - High-byte strap low restores I/O 26, 29
// - I/O 4,5,7,8,9 offer pullup input setting
// - Ready pin I/O 6 offers pulldown setting
// - Boot width strap latched at reset release
// - 8-bit boot lets software change upper width
// - Status bit 2 drives memory/io, floats on hold
`ifndef RBS_CFG_SVH
`define RBS_CFG_SVH
`define RBS_BOOT_VECTOR 20'hffff0
`define RBS_FETCH_DELAY 3'h6
`define RBS_SYNC_LAT 3'h3
`define RBS_PIO_NUM 32
`define RBS_PIO_NORMAL 32'h000003f0
`define RBS_PIO_PULLDN 32'h00000402
`define RBS_PIO_PULLUP_OPT 32'h000003b0
`define RBS_PIO_PULLDN_OPT 32'h00000040
`define RBS_PIO_STRAP_BACK 32'h24000000
`define RBS_CFG_RESET 32'h00000000
`endif

// ---- rbs_pkg.sv ----
// Types for the reset and boot strap configuration block.
// Assumes rbs_cfg.svh holds the numeric constants.
package rbs_pkg;
	typedef enum logic [1:0] {
		RBS_ST_RESET = 2'b00,
		RBS_ST_WAIT = 2'b01,
		RBS_ST_RUN = 2'b10
	} rbs_state_type;

	typedef struct packed {
		logic [31:0] pio_en;
		logic [31:0] pio_dir_out;
		logic [31:0] pio_pullup;
		logic [31:0] pio_pulldn;
	} rbs_pio_type;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic sync_prev;
		rbs_state_type state;
		logic [2:0] cnt;
		logic boot8;
		logic hb_low;
		logic core_clear;
		logic fetch_start;
		logic [19:0] fetch_addr;
		logic upper8;
		rbs_pio_type programmable_io;
		logic s2_out;
		logic s2_oe;
	} rbs_state_rec_type;
endpackage

// ---- rbs_top.sv ----
// Reset entry, strap capture and power-on pin defaults.
// Assumes straps are driven resistively and inputs other than nrst and system_init_in_n are synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
`include "rbs_cfg.svh"
module rbs_top
	import rbs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic system_init_in_n,
	input wire logic boot_width_strap_in,
	input wire logic high_byte_strap_in,
	input wire logic bus_cycle_active,
	input wire logic bus_cycle_mem,
	input wire logic bus_hold,
	input wire logic cfg_wr,
	input wire rbs_pio_type cfg_pio,
	input wire logic cfg_upper8,
	output logic core_clear,
	output logic fetch_start,
	output logic [19:0] fetch_addr,
	output logic boot8_mode,
	output logic upper_mem_select_8bit,
	output rbs_pio_type pio_cfg,
	output logic cycle_status_bit2_out,
	output logic cycle_status_bit2_oe
);
	rbs_state_rec_type st_r;
	rbs_state_rec_type st_nxt;
	logic rel_edge;
	rbs_pio_type pio_def;

	////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		rel_edge = st_r.sync2 & ~st_r.sync_prev;
		pio_def.pio_en = ~`RBS_PIO_NORMAL;
		if (st_r.hb_low) begin
			pio_def.pio_en = ~(`RBS_PIO_NORMAL | `RBS_PIO_STRAP_BACK);
		end
		pio_def.pio_dir_out = '0;
		pio_def.pio_pulldn = `RBS_PIO_PULLDN;
		pio_def.pio_pullup = ~(`RBS_PIO_PULLDN | `RBS_PIO_NORMAL);
		// Two-flop synchronizer, second stage only is used
		st_nxt.sync1 = system_init_in_n;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.sync_prev = st_r.sync2;
		st_nxt.fetch_start = 1'b0;
		case (st_r.state)
			RBS_ST_RESET: begin
				st_nxt.core_clear = 1'b1;
				st_nxt.cnt = '0;
				st_nxt.programmable_io = pio_def;
				st_nxt.upper8 = 1'b0;
				if (rel_edge) begin
					st_nxt.boot8 = ~boot_width_strap_in;
					st_nxt.hb_low = ~high_byte_strap_in;
					st_nxt.state = RBS_ST_WAIT;
				end
			end
			RBS_ST_WAIT: begin
				// Release edge already costs three sync stages
				st_nxt.cnt = st_r.cnt + 3'h1;
				st_nxt.programmable_io = pio_def;
				if (st_r.cnt == `RBS_FETCH_DELAY - `RBS_SYNC_LAT) begin
					st_nxt.core_clear = 1'b0;
					st_nxt.fetch_start = 1'b1;
					st_nxt.fetch_addr = `RBS_BOOT_VECTOR;
					st_nxt.state = RBS_ST_RUN;
				end
			end
			RBS_ST_RUN: begin
				if (cfg_wr) begin
					// Pulldown only where the pin supports it; pullup on every pin except I/O 6
					st_nxt.programmable_io.pio_en = cfg_pio.pio_en;
					st_nxt.programmable_io.pio_dir_out = cfg_pio.pio_dir_out;
					st_nxt.programmable_io.pio_pullup = cfg_pio.pio_pullup
						& ~`RBS_PIO_PULLDN_OPT;
					st_nxt.programmable_io.pio_pulldn = cfg_pio.pio_pulldn
						& (`RBS_PIO_PULLDN | `RBS_PIO_PULLDN_OPT);
					if (st_r.boot8) begin
						st_nxt.upper8 = cfg_upper8;
					end
				end
			end
			default: begin
				st_nxt.state = RBS_ST_RESET;
			end
		endcase
		if (!st_r.sync2) begin
			st_nxt.state = RBS_ST_RESET;
			st_nxt.core_clear = 1'b1;
			st_nxt.fetch_start = 1'b0;
		end
		st_nxt.s2_oe = bus_cycle_active & ~bus_hold & (st_r.state == RBS_ST_RUN);
		st_nxt.s2_out = bus_cycle_active ? bus_cycle_mem : 1'b1;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
			st_r.core_clear <= 1'b1;
			st_r.state <= RBS_ST_RESET;
			st_r.fetch_addr <= `RBS_BOOT_VECTOR;
			st_r.s2_out <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	assign core_clear = st_r.core_clear;
	assign fetch_start = st_r.fetch_start;
	assign fetch_addr = st_r.fetch_addr;
	assign boot8_mode = st_r.boot8;
	assign upper_mem_select_8bit = st_r.upper8;
	assign pio_cfg = st_r.programmable_io;
	assign cycle_status_bit2_out = st_r.s2_out;
	assign cycle_status_bit2_oe = st_r.s2_oe;
endmodule
`default_nettype wire

// ---- rbs_monitor.sv ----
// Checker for rbs_top ports.
// Assumes one clock, bound below.
`timescale 1ns/1ns
`default_nettype none
module rbs_monitor import rbs_pkg::*; (
	input wire logic clk_sys, nrst, system_init_in_n, boot_width_strap_in, bus_hold,
	input wire logic high_byte_strap_in, bus_cycle_active, core_clear, fetch_start,
	input wire logic boot8_mode, cycle_status_bit2_oe,
	input wire logic [19:0] fetch_addr,
	input wire rbs_pio_type pio_cfg
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence s_lo; !system_init_in_n [*3]; endsequence
	sequence s_up; s_lo ##1 system_init_in_n [*3]; endsequence
	property p_go; s_up ##1 system_init_in_n [*4] |=> fetch_start; endproperty
	a_go: assert property (p_go) else $error("late fetch");
	property p_pc; fetch_start |-> fetch_addr == 20'hffff0; endproperty
	a_pc: assert property (p_pc) else $error("bad vector");
	property p_cl; s_lo |=> core_clear; endproperty
	a_cl: assert property (p_cl) else $error("no clear");
	property p_bw; s_up |=> boot8_mode == !$past(boot_width_strap_in); endproperty
	a_bw: assert property (p_bw) else $error("bad strap");
	property p_df; fetch_start |-> pio_cfg.pio_en[9:0] == 10'h00f; endproperty
	a_df: assert property (p_df) else $error("bad default");
	property p_hb; fetch_start |-> pio_cfg.pio_en[29:26] == {high_byte_strap_in, 2'h3,
		high_byte_strap_in}; endproperty
	a_hb: assert property (p_hb) else $error("bad restore");
	property p_s2; !core_clear && bus_cycle_active && !bus_hold |=> cycle_status_bit2_oe;
	endproperty
	a_s2: assert property (p_s2) else $error("status idle");
	property p_hz; bus_hold |=> !cycle_status_bit2_oe; endproperty
	a_hz: assert property (p_hz) else $error("status driven");
endmodule
bind rbs_top rbs_monitor CHK(.*);
`default_nettype wire

// ---- rbs_rst_gen.sv ----
// Reset source and strap resistors.
// Assumes the bench calls req.
`timescale 1ns/1ns
`default_nettype none
module rbs_rst_gen (
	input wire logic clk_sys,
	output logic system_init_in_n = 1'h0, boot_width_strap_in = 1'h1, high_byte_strap_in = 1'h1
);
	task automatic req(input int n, input logic b, h);
		@(negedge clk_sys);
		system_init_in_n = 1'h0; // short span, clock keeps running
		boot_width_strap_in = b; // weak pull only
		high_byte_strap_in = h;
		repeat (n) @(negedge clk_sys);
		system_init_in_n = 1'h1;
	endtask
endmodule
`default_nettype wire

// ---- rbs_top_tb_top.sv ----
// Random reset and pin write bench.
// Assumes rbs_rst_gen as reset source.
`timescale 1ns/1ns
`default_nettype none
module rbs_top_tb_top import rbs_pkg::*; ;
	logic clk_sys = '0, nrst = '0, cfg_wr = '0, bus_cycle_active, bus_cycle_mem, bus_hold;
	logic cfg_upper8, system_init_in_n, boot_width_strap_in, high_byte_strap_in, core_clear;
	logic fetch_start, boot8_mode, upper_mem_select_8bit, cycle_status_bit2_out, x;
	logic cycle_status_bit2_oe;
	logic [19:0] fetch_addr;
	rbs_pio_type cfg_pio, pio_cfg;
	int seed = 57134, n_fail = 0, samples_checked = 0, i, k;
	always #5 clk_sys = ~clk_sys;
	rbs_rst_gen GEN(.*);
	rbs_top DUT(.*);
	function automatic rbs_pio_type fix(input rbs_pio_type c);
		c.pio_pullup[6] = 1'h0;
		c.pio_pulldn &= 32'h442;
		return c;
	endfunction
	task automatic chk(input string s, input logic [127:0] e, v);
		samples_checked++;
		n_fail += (e !== v);
		if (e !== v) $display("unexpected %s exp %0h got %0h", s, e, v);
	endtask
	task automatic stop_test;
		$display("checks %0d fails %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#20000 n_fail++;
		stop_test;
	end
	initial begin
		{bus_cycle_active, bus_cycle_mem, bus_hold, cfg_upper8, cfg_pio} = '0;
		repeat (2) @(negedge clk_sys);
		nrst = 1'h1;
		for (i = 0; i < 16; i++) begin
			x = $random(seed);
			GEN.req(3 + (i < 2 ? 0 : $unsigned($random(seed)) % 9), x, $random(seed));
			for (k = 0; k < 20 && fetch_start !== 1'h1; k++) @(negedge clk_sys);
			chk("delay", 7, k);
			chk("clear", 1'h0, core_clear);
			chk("vector", 20'hffff0, fetch_addr);
			chk("boot8", !x, boot8_mode);
			repeat (8) begin
				{bus_cycle_active, bus_cycle_mem, bus_hold, cfg_upper8, cfg_wr} = $random(seed);
				cfg_pio = {$random(seed), $random(seed), $random(seed), $random(seed)};
				@(negedge clk_sys);
				if (cfg_wr) chk("pio", fix(cfg_pio), pio_cfg);
				if (cfg_wr && !x) chk("upper", cfg_upper8, upper_mem_select_8bit);
				else if (x) chk("upper", 1'h0, upper_mem_select_8bit);
				chk("s2oe", bus_cycle_active & !bus_hold, cycle_status_bit2_oe);
				chk("s2", bus_cycle_active ? bus_cycle_mem : 1'h1, cycle_status_bit2_out);
			end
			cfg_wr = 1'h0;
			$display("reset %0d done", i);
		end
		stop_test;
	end
endmodule
`default_nettype wire
